// File: rtl/ldc_top.sv
/*
  Indicator lamp direct control: one 16-bit control register that
  selects, per lamp, the built-in indicator drive or a direct on/off
  bit, plus a polarity bit, and a read-only status register.
  Assumes a classic Wishbone master on clk_i and built-in indicator
  levels produced by logic on the same clock.
*/
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////
// Function
// - Bits 15:12 set lamp polarity; 0 drives pin high when lit, 1 low.
// - Bits 11:8 connect the built-in indicator function to each lamp.
// - With the built-in function off, a lamp stays dark unless its direct bit is set.
// - Bits 3:0 switch each lamp on (1) or off (0) directly.
// - Bits 7:4 are reserved, read-only; written zero, read value meaningless.
// - A directly controlled lamp is isolated from the built-in function.
module ldc_top
  import ldc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [LDC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [LDC_DATA_W-1:0] wb_dat_i,
  output logic      [LDC_DATA_W-1:0] wb_dat_o,
  output logic                       wb_ack_o,
  // Built-in indicator drive
  input  wire logic [LDC_LAMPS-1:0]  builtin_lamp_i,
  // Lamp pins
  output logic      [LDC_LAMPS-1:0]  lamp_pin_o
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [LDC_REG_W-1:0]  ctrl_reg;
  logic [LDC_REG_W-1:0]  ctrl_next;
  logic                  ack_reg;
  logic [LDC_DATA_W-1:0] rdat_reg;
  logic [LDC_DATA_W-1:0] rdat_next;
  logic [LDC_LAMPS-1:0]  lit_reg;
  logic [LDC_LAMPS-1:0]  lit_next;
  logic [LDC_LAMPS-1:0]  pin_reg;
  logic [LDC_LAMPS-1:0]  pin_next;
  logic                  req;
  logic                  wr_fire;
  logic                  wr_ctrl;

  ////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths
  function automatic logic addr_hit(
    input logic [LDC_ADDR_W-1:0] adr,
    input logic [7:0]            target
  );
    addr_hit = (adr[LDC_ADDR_W-1:2] == target[LDC_ADDR_W-1:2]);
  endfunction

  assign req     = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_fire = req & wb_we_i & ack_reg;
  assign wr_ctrl = wr_fire & addr_hit(wb_adr_i, LDC_ADR_CTRL);

  ////////////////////////////////////////////////////////////////////
  // Acknowledge: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control register write, byte lanes 0 and 1 only
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        ctrl_next[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_next[15:8] = wb_dat_i[15:8];
      end
    end
    // Reserved bits never store, whatever software writes
    ctrl_next = ctrl_next & LDC_CTRL_WMASK;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= LDC_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, captured with the ack so it stands while ack is high
  always_comb begin
    rdat_next = LDC_RD_ZERO;
    if (req & ~ack_reg & ~wb_we_i) begin
      if (addr_hit(wb_adr_i, LDC_ADR_CTRL)) begin
        rdat_next[LDC_REG_W-1:0] = ctrl_reg & LDC_CTRL_WMASK;
      end else if (addr_hit(wb_adr_i, LDC_ADR_STAT)) begin
        rdat_next[LDC_STAT_LIT +: LDC_LAMPS] = lit_reg;
        rdat_next[LDC_STAT_PIN +: LDC_LAMPS] = pin_reg;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdat_reg <= LDC_RD_ZERO;
    end else begin
      rdat_reg <= rdat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-lamp source select and polarity
  // Software is trusted to clear the enable before using direct bits
  generate
    for (genvar i = 0; i < LDC_LAMPS; i++) begin : g_lamp
      always_comb begin
        if (ctrl_reg[LDC_EN_LSB + i]) begin
          lit_next[i] = builtin_lamp_i[i];
        end else begin
          // Built-in drive is cut off here; only the direct bit counts
          lit_next[i] = ctrl_reg[LDC_DIR_LSB + i];
        end
        pin_next[i] = lit_next[i] ^ ctrl_reg[LDC_POL_LSB + i];
      end
    end
  endgenerate

  // Registered pins keep glitches off the board; costs one cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lit_reg <= '0;
      pin_reg <= '0;
    end else begin
      lit_reg <= lit_next;
      pin_reg <= pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rdat_reg;
  assign lamp_pin_o = pin_reg;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_pin_polarity: assert property (
    ##1 lamp_pin_o == (lit_reg ^ $past(ctrl_reg[LDC_POL_LSB +: LDC_LAMPS]))
  ) else $error("Lamp pin does not follow lit state and polarity");

  a_builtin_drives: assert property (
    (ctrl_reg[LDC_EN_LSB +: LDC_LAMPS] == 4'hf)
    |=> (lit_reg == $past(builtin_lamp_i))
  ) else $error("Enabled lamp does not follow built-in drive");

  a_disabled_dark: assert property (
    (!ctrl_reg[LDC_EN_LSB] && !ctrl_reg[LDC_DIR_LSB])
    |=> !lit_reg[0] ##1 1'b1
  ) else $error("Disabled lamp lit without direct command");

  a_direct_lights: assert property (
    (!ctrl_reg[LDC_EN_LSB + 3] && ctrl_reg[LDC_DIR_LSB + 3])
    |=> (lit_reg[3] && (lamp_pin_o[3] == !$past(ctrl_reg[LDC_POL_LSB + 3])))
  ) else $error("Direct on bit did not light lamp");

  a_reserved_zero: assert property (
    ctrl_reg[LDC_RSV_LSB +: 4] == 4'h0
  ) else $error("Reserved control bits hold a value");

  a_reserved_read: assert property (
    (wb_ack_o && !wb_we_i && addr_hit(wb_adr_i, LDC_ADR_CTRL))
    |-> (wb_dat_o[LDC_RSV_LSB +: 4] == 4'h0)
  ) else $error("Reserved bits read non-zero");

  a_builtin_isolated: assert property (
    (ctrl_reg[LDC_EN_LSB +: LDC_LAMPS] == 4'h0)
    |=> (lit_reg == $past(ctrl_reg[LDC_DIR_LSB +: LDC_LAMPS]))
  ) else $error("Built-in drive leaks into direct lamp");

  a_write_effect: assert property (
    (wr_ctrl && wb_sel_i[0] && (ctrl_reg[LDC_EN_LSB +: 4] == 4'h0)
      && wb_sel_i[1] && (wb_dat_i[LDC_EN_LSB +: 4] == 4'h0))
    |=> (ctrl_reg[3:0] == $past(wb_dat_i[3:0]))
        ##1 (lamp_pin_o == ($past(ctrl_reg[3:0]) ^ $past(ctrl_reg[15:12])))
  ) else $error("Control write not seen on pins one cycle later");

  a_ack_single: assert property (
    (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("Ack not given for exactly one cycle");

  ////////////////////////////////////////////////////////////////////
  // Bus checks
  a_ack_needs_req: assert property (
    wb_ack_o |-> $past(req)
  ) else $error("Ack without a preceding request");

  // A master that holds stb past ack starts a new access
  a_ack_drops: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("Ack held longer than one cycle");

  // Idle data is zero so a stray bus sample shows nothing stale
  a_idle_data_zero: assert property (
    !wb_ack_o |-> (wb_dat_o == LDC_RD_ZERO)
  ) else $error("Read data not zero outside a read ack");

  a_unmapped_zero: assert property (
    (wb_ack_o && !wb_we_i && !addr_hit(wb_adr_i, LDC_ADR_CTRL)
      && !addr_hit(wb_adr_i, LDC_ADR_STAT))
    |-> (wb_dat_o == LDC_RD_ZERO)
  ) else $error("Unmapped read returned data");

  ////////////////////////////////////////////////////////////////////
  // Register checks
  a_write_lands: assert property (
    (wr_ctrl && (wb_sel_i[1:0] == 2'b11))
    |=> (ctrl_reg == ($past(wb_dat_i[LDC_REG_W-1:0]) & LDC_CTRL_WMASK))
  ) else $error("Control write did not land");

  // Writes elsewhere must leave the control word alone
  a_ctrl_write_only: assert property (
    !wr_ctrl |=> $stable(ctrl_reg)
  ) else $error("Control register changed without a write");

  // Status is taken at the request edge, not the ack edge
  a_stat_readback: assert property (
    (req && !wb_ack_o && !wb_we_i && addr_hit(wb_adr_i, LDC_ADR_STAT))
    |=> ((wb_dat_o[LDC_STAT_LIT +: LDC_LAMPS] == $past(lit_reg))
         && (wb_dat_o[LDC_STAT_PIN +: LDC_LAMPS] == $past(pin_reg)))
  ) else $error("Status read does not show lamp state");

  ////////////////////////////////////////////////////////////////////
  // Per-lamp checks, one set per lamp so a failure names the lamp
  generate
    for (genvar k = 0; k < LDC_LAMPS; k++) begin : g_lamp_chk
      a_lamp_builtin: assert property (
        ctrl_reg[LDC_EN_LSB + k]
        |=> (lit_reg[k] == $past(builtin_lamp_i[k]))
      ) else $error("Enabled lamp ignores its built-in drive");

      a_lamp_direct: assert property (
        !ctrl_reg[LDC_EN_LSB + k]
        |=> (lit_reg[k] == $past(ctrl_reg[LDC_DIR_LSB + k]))
      ) else $error("Disabled lamp does not follow its direct bit");

      a_lamp_dark: assert property (
        (!ctrl_reg[LDC_EN_LSB + k] && !ctrl_reg[LDC_DIR_LSB + k])
        |=> !lit_reg[k]
      ) else $error("Disabled lamp lit without a direct command");

      a_lamp_level: assert property (
        lamp_pin_o[k] == (lit_reg[k] ^ $past(ctrl_reg[LDC_POL_LSB + k]))
      ) else $error("Lamp pin level disagrees with polarity");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Cover points
  c_ctrl_write: cover property (
    wr_ctrl ##1 (ctrl_reg[LDC_EN_LSB +: 4] == 4'h0)
  );

  c_stat_read: cover property (
    wb_ack_o && !wb_we_i && addr_hit(wb_adr_i, LDC_ADR_STAT)
  );

  c_active_low: cover property (
    (lit_next[0] && ctrl_reg[LDC_POL_LSB]) ##1 !lamp_pin_o[0]
  );

  c_direct_lit: cover property (
    (!ctrl_reg[LDC_EN_LSB + 3] && ctrl_reg[LDC_DIR_LSB + 3]) ##1 lit_reg[3]
  );

  c_unmapped_read: cover property (
    wb_ack_o && !wb_we_i && !addr_hit(wb_adr_i, LDC_ADR_CTRL) && !addr_hit(wb_adr_i, LDC_ADR_STAT)
  );

endmodule

`default_nettype wire

// File: rtl/ldc_pkg.sv
/*
  Constants for the indicator lamp direct control block: register
  indices, byte addresses, field positions, reset values and masks.
  Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
`default_nettype none
package ldc_pkg;

  ////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int          LDC_LAMPS      = 4;
  localparam int          LDC_DATA_W     = 32;
  localparam int          LDC_ADDR_W     = 8;
  localparam int          LDC_REG_W      = 16;

  ////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0]  LDC_IDX_CTRL   = 8'h11;
  localparam logic [7:0]  LDC_IDX_STAT   = 8'h12;
  localparam logic [7:0]  LDC_ADR_CTRL   = LDC_IDX_CTRL << 2;
  localparam logic [7:0]  LDC_ADR_STAT   = LDC_IDX_STAT << 2;

  ////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int          LDC_POL_LSB    = 12;
  localparam int          LDC_EN_LSB     = 8;
  localparam int          LDC_RSV_LSB    = 4;
  localparam int          LDC_DIR_LSB    = 0;
  localparam logic [15:0] LDC_CTRL_RST   = 16'h0f00;
  localparam logic [15:0] LDC_CTRL_WMASK = 16'hff0f;

  ////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int          LDC_STAT_LIT   = 0;
  localparam int          LDC_STAT_PIN   = 8;

  ////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [31:0] LDC_RD_ZERO    = 32'h0000_0000;

endpackage

`default_nettype wire

// File: tb/ldc_lamp_model.sv
/*
  Lamp model: four indicator lamps hung on the lamp pins.
  Assumes the bench hands it the polarity it has programmed.
*/
`timescale 1ns/1ns
`default_nettype none
module ldc_lamp_model
  import ldc_pkg::*;
(
  // Pins and polarity
  input  wire logic [LDC_LAMPS-1:0] pin_i,
  input  wire logic [LDC_LAMPS-1:0] pol_i,
  // Lamp state as seen
  output logic      [LDC_LAMPS-1:0] lit_o
);
  // A low-active lamp glows on a low pin
  assign lit_o = pin_i ^ pol_i;
endmodule
`default_nettype wire

// File: tb/indicator_direct_control_tb.sv
/*
  Bench for the lamp control block: Wishbone tasks and lamp checks.
  Assumes ldc_top with one-cycle ack and the lamp model.
*/
`timescale 1ns/1ns
`default_nettype none
module indicator_direct_control_tb
  import ldc_pkg::*;
;
  logic        clk_i      = 1'b0;
  logic        reset_i    = 1'b1;
  logic        cyc        = 1'b0;
  logic        stb        = 1'b0;
  logic        we         = 1'b0;
  logic [7:0]  adr        = 8'h00;
  logic [3:0]  sel        = 4'h0;
  logic [3:0]  bl         = 4'h0;
  logic [3:0]  pol        = 4'h0;
  logic [31:0] wdat       = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [3:0]  pins;
  logic [3:0]  lit;
  logic        ack;
  int          err_total  = 0;
  int          num_checks = 0;
  always #4 clk_i = ~clk_i;
  ldc_top DUT (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .builtin_lamp_i(bl), .lamp_pin_o(pins));
  ldc_lamp_model lamps (.pin_i(pins), .pol_i(pol), .lit_o(lit));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ack is sampled; only the watchdog ends a dead wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic settle(input logic [3:0] b);
    bl <= b;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, LDC_ADR_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_ff0f, 32'h0000_0f00);
    settle(4'b1010);
    chk(pins, 4'b1010);
    $display("Test reset and built-in drive done");
    wb(1'b1, LDC_ADR_CTRL, 32'h0000_0005);
    settle(4'b1111);
    chk(pins, 4'b0101);
    settle(4'b0000);
    chk(pins, 4'b0101);
    wb(1'b0, LDC_ADR_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_ff0f, 32'h0000_0005);
    $display("Test direct drive done");
    pol <= 4'hf;
    wb(1'b1, LDC_ADR_CTRL, 32'h0000_f005);
    settle(4'b1111);
    chk(pins, 4'b1010);
    chk(lit, 4'b0101);
    wb(1'b1, LDC_ADR_CTRL, 32'h0000_f000);
    settle(4'b1111);
    chk(pins, 4'b1111);
    $display("Test polarity done");
    pol <= 4'h3;
    bl  <= 4'b0101;
    wb(1'b1, LDC_ADR_CTRL, 32'h0000_3609);
    @(posedge clk_i);
    chk(pins, 4'b1110);
    wb(1'b0, LDC_ADR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0e0d);
    wb(1'b0, 8'h80, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("Test mixed sources done");
    report_and_stop;
  end
  // Whole run needs about fifty cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
